// *** hw/blfc_pkg.sv ***
package blfc_pkg;

  // time base: timers count ticks of 0.1 s, fades advance in 128 steps per tick
  localparam int CLK_PERIOD_NS   = 5;
  localparam int TICK_TIME_MS    = 100;
  localparam int TICK_CYCLES     = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STEPS_PER_TICK  = 128;
  localparam int STEP_CYCLES_DEF = TICK_CYCLES / STEPS_PER_TICK;
  localparam logic [7:0] FADE_END = 8'h80;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_MODE   = 4'h0;
  localparam logic [3:0] IDX_CTRL   = 4'h2;
  localparam logic [3:0] IDX_TIMERS = 4'h3;
  localparam logic [3:0] IDX_FADES  = 4'h4;
  localparam logic [3:0] IDX_FULL   = 4'h5;
  localparam logic [3:0] IDX_DIM    = 4'h6;
  localparam logic [3:0] IDX_VALUE  = 4'hB;

  localparam logic [7:0] RST_MODE   = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_TIMERS = 8'h00;
  localparam logic [7:0] RST_FADES  = 8'h00;
  localparam logic [6:0] RST_CODE   = 7'h00;

  localparam int MODE_STBY_BIT = 7;
  localparam int MODE_DRV_BIT  = 6;
  localparam int MODE_DIM_BIT  = 5;
  localparam int CTRL_LVL_LSB  = 6;
  localparam int CTRL_CRV_LSB  = 4;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int CTRL_OVP_BIT  = 2;
  localparam int CTRL_BYP_BIT  = 1;
  localparam int CTRL_KEY_BIT  = 0;
  localparam int HI_NIB_LSB    = 4;

  typedef enum logic [1:0] {LVL_DAY = 2'h0, LVL_OFFICE = 2'h1, LVL_DARK = 2'h2} blfc_level_t;
  typedef enum logic [1:0] {CRV_LIN = 2'h0, CRV_SQR = 2'h1, CRV_CUB1 = 2'h2, CRV_CUB2 = 2'h3} blfc_curve_t;

  // off and dim delay in ticks, zero means disabled
  function automatic logic [10:0] blfc_delay_ticks(input logic [3:0] c);
    logic [10:0] k;
    k = {7'h00, c};
    if (c == 4'h0) return 11'h000;
    if (c < 4'h8) return 11'(11'h032 + k * 11'h032);
    return 11'(11'h1F4 + (k - 11'h008) * 11'h064);
  endfunction : blfc_delay_ticks

  // fade duration in ticks, zero means no fade
  function automatic logic [5:0] blfc_fade_ticks(input logic [3:0] c);
    logic [5:0] k;
    k = {2'h0, c};
    if (c < 4'hB) return 6'(k * 6'h03);
    return 6'(6'h23 + (k - 6'h0B) * 6'h05);
  endfunction : blfc_fade_ticks

endpackage : blfc_pkg

// *** hw/blfc_fade_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface blfc_fade_if;
  logic [6:0] target;
  logic [5:0] dur;
  logic [1:0] curve;
  logic       jump;
  logic       step;
  logic [6:0] code;
  logic       busy;
  modport ctrl  (output target, dur, curve, jump, step, input code, busy);
  modport fader (input target, dur, curve, jump, step, output code, busy);
endinterface : blfc_fade_if
`default_nettype wire

// *** hw/blfc_fader.sv ***
`timescale 1ns/10ps
`default_nettype none
module blfc_fader
  import blfc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fade request and present code
  blfc_fade_if.fader fi
);
  typedef enum {FD_IDLE, FD_RUN} blfc_fstate_t;
  blfc_fstate_t state;
  logic [6:0] from_code;
  logic [6:0] to_code;
  logic [7:0] pos;
  logic [5:0] sub;

  wire logic [7:0]  p     = pos;
  wire logic [7:0]  q     = 8'(FADE_END - pos);
  wire logic [15:0] pp    = {8'h00, p} * {8'h00, p};
  wire logic [15:0] ppp   = {8'h00, pp[14:7]} * {8'h00, p};
  wire logic [15:0] qq    = {8'h00, q} * {8'h00, q};
  wire logic [15:0] qqq   = {8'h00, qq[14:7]} * {8'h00, q};
  logic [7:0] frac;
  always_comb begin
    case (blfc_curve_t'(fi.curve))
      CRV_LIN:  frac = p;
      CRV_SQR:  frac = pp[14:7];
      CRV_CUB1: frac = ppp[14:7];
      CRV_CUB2: frac = 8'(FADE_END - qqq[14:7]);
      default:  frac = p;
    endcase
  end
  wire logic [7:0]  delta  = {1'b0, to_code} - {1'b0, from_code};
  wire logic [15:0] prod   = $signed({{8{delta[7]}}, delta}) * $signed({8'h00, frac});
  wire logic [7:0]  sum    = {1'b0, from_code} + prod[14:7];
  wire logic        retarget = fi.target != to_code;
  wire logic        sub_end  = sub == 6'(fi.dur - 6'h01);

  assign fi.code = sum[6:0];
  assign fi.busy = state == FD_RUN;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state     <= FD_IDLE;
      from_code <= RST_CODE;
      to_code   <= RST_CODE;
      pos       <= FADE_END;
      sub       <= 6'h00;
    end else if (retarget) begin
      // a new target restarts from wherever the present fade has reached, or is taken at once when jump is set
      to_code   <= fi.target;
      from_code <= fi.jump ? fi.target : sum[6:0];
      pos       <= fi.jump ? FADE_END : 8'h00;
      state     <= fi.jump ? FD_IDLE : FD_RUN;
      sub       <= 6'h00;
    end else if (state == FD_RUN && fi.step) begin
      sub <= sub_end ? 6'h00 : 6'(sub + 6'h01);
      if (sub_end) begin
        pos <= 8'(pos + 8'h01);
        if (pos == 8'(FADE_END - 8'h01)) state <= FD_IDLE;
      end
    end
  end

  chk_fade_jump: assert property (@(posedge clk) disable iff (!nrst)
    retarget && fi.jump |=> fi.code == $past(fi.target) && !fi.busy) else $error("bypassed fade did not jump");
  chk_fade_reach: assert property (@(posedge clk) disable iff (!nrst)
    $fell(fi.busy) |-> fi.code == to_code) else $error("fade ended off target");
endmodule : blfc_fader
`default_nettype wire

// *** hw/blfc_top.sv ***
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module blfc_top
  import blfc_pkg::*;
#(
  parameter int         STEP_CYCLES    = STEP_CYCLES_DEF,
  parameter logic [6:0] OTHER_FULL_CODE = 7'h00,
  parameter logic [6:0] OTHER_DIM_CODE  = 7'h00
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm register slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  // pins from keypad, boost monitor and light comparators
  input  wire logic        key_press,
  input  wire logic        overvoltage,
  input  wire logic        ambient_l2,
  input  wire logic        ambient_l3,
  // backlight sink control
  output var  logic [6:0]  sink_code,
  output var  logic        driver_enable
);
  // register bus
  wire logic [3:0] idx     = address[5:2];
  wire logic       req     = (read || write) && waitrequest;
  wire logic       wr_go   = write && !waitrequest && byteenable[0];
  wire logic [7:0] wbyte   = writedata[7:0];
  wire logic       wr_mode = wr_go && idx == IDX_MODE;
  wire logic       wr_ctrl = wr_go && idx == IDX_CTRL;
  wire logic       wr_tim  = wr_go && idx == IDX_TIMERS;
  wire logic       wr_fade = wr_go && idx == IDX_FADES;
  wire logic       wr_full = wr_go && idx == IDX_FULL;
  wire logic       wr_dim  = wr_go && idx == IDX_DIM;

  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] timers_reg;
  logic [7:0] fades_reg;
  logic [6:0] full_code;
  logic [6:0] dim_code;

  // pin synchronisers: stage one is read only by stage two
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       key_prev;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1    <= 4'h0;
      sync2    <= 4'h0;
      key_prev <= 1'b0;
    end else begin
      sync1    <= {ambient_l3, ambient_l2, overvoltage, key_press};
      sync2    <= sync1;
      key_prev <= sync2[0];
    end
  end
  wire logic key_rise = sync2[0] && !key_prev;
  wire logic ovp_seen = sync2[1];

  // fields
  wire logic        standby_n       = mode_reg[MODE_STBY_BIT];
  wire logic        light_driver_on = mode_reg[MODE_DRV_BIT];
  wire logic        dim_enable      = mode_reg[MODE_DIM_BIT];
  wire blfc_level_t brightness_level_select = blfc_level_t'(ctrl_reg[CTRL_LVL_LSB +: 2]);
  wire logic [1:0]  fade_curve_select           = ctrl_reg[CTRL_CRV_LSB +: 2];
  wire logic        auto_level_adjust           = ctrl_reg[CTRL_AUTO_BIT];
  wire logic        overvoltage_rampdown_enable = ctrl_reg[CTRL_OVP_BIT];
  wire logic        fade_bypass                 = ctrl_reg[CTRL_BYP_BIT];
  wire logic        keypress_wake_light         = ctrl_reg[CTRL_KEY_BIT];
  wire logic [3:0]  off_delay_code     = timers_reg[HI_NIB_LSB +: 4];
  wire logic [3:0]  dim_delay_code     = timers_reg[3:0];
  wire logic [3:0]  fade_out_time_code = fades_reg[HI_NIB_LSB +: 4];
  wire logic [3:0]  fade_in_time_code  = fades_reg[3:0];

  // comparator level: dark wins over office
  wire blfc_level_t auto_level = sync2[3] ? LVL_DARK : (sync2[2] ? LVL_OFFICE : LVL_DAY);

  // time base
  logic [31:0] step_cnt;
  logic [6:0]  step_in_tick;
  wire  logic  step = step_cnt == 32'(STEP_CYCLES - 1);
  wire  logic  tick = step && step_in_tick == 7'(STEPS_PER_TICK - 1);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      step_cnt     <= 32'h0000_0000;
      step_in_tick <= 7'h00;
    end else begin
      step_cnt <= step ? 32'h0000_0000 : 32'(step_cnt + 32'h0000_0001);
      if (step) step_in_tick <= 7'(step_in_tick + 7'h01);
    end
  end

  // inactivity timer: restarted by key presses and while the driver is off
  logic [10:0] idle_ticks;
  wire  logic [10:0] off_lim = blfc_delay_ticks(off_delay_code);
  wire  logic [10:0] dim_lim = blfc_delay_ticks(dim_delay_code);
  wire  logic active   = light_driver_on && standby_n;
  wire  logic key_wake = key_rise && keypress_wake_light && standby_n;
  wire  logic idle_rst = !active || key_rise;
  wire  logic off_expire = active && tick && !key_rise && off_lim != 11'h000 && idle_ticks == 11'(off_lim - 11'h001);
  wire  logic dim_expire = active && tick && !key_rise && dim_lim != 11'h000 && idle_ticks == 11'(dim_lim - 11'h001);
  always_ff @(posedge clk) begin
    if (!nrst) idle_ticks <= 11'h000;
    else if (idle_rst) idle_ticks <= 11'h000;
    else if (tick && idle_ticks != 11'h7FF) idle_ticks <= 11'(idle_ticks + 11'h001);
  end

  // dim set by the timer may be undone by a key press; dim set by software stays until software clears it
  logic dim_auto;
  always_ff @(posedge clk) begin
    if (!nrst) dim_auto <= 1'b0;
    else if (dim_expire) dim_auto <= 1'b1;
    else if (wr_mode || key_wake) dim_auto <= 1'b0;
  end

  // mode register: hardware sets win over software writes
  logic [7:0] next_mode;
  always_comb begin
    next_mode = wr_mode ? wbyte : mode_reg;
    if (off_expire) next_mode[MODE_DRV_BIT] = 1'b0;
    if (key_wake) next_mode[MODE_DRV_BIT] = 1'b1;
    if (dim_expire) next_mode[MODE_DIM_BIT] = 1'b1;
    if (key_wake && dim_auto) next_mode[MODE_DIM_BIT] = 1'b0;
    next_mode[4:0] = 5'h00;
  end

  // control register: in auto mode the level bits belong to hardware
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = wr_ctrl ? wbyte : ctrl_reg;
    if (auto_level_adjust) next_ctrl[CTRL_LVL_LSB +: 2] = auto_level;
    if (next_ctrl[CTRL_LVL_LSB +: 2] == 2'h3) next_ctrl[CTRL_LVL_LSB +: 2] = ctrl_reg[CTRL_LVL_LSB +: 2];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_reg   <= RST_MODE;
      ctrl_reg   <= RST_CTRL;
      timers_reg <= RST_TIMERS;
      fades_reg  <= RST_FADES;
      full_code  <= RST_CODE;
      dim_code   <= RST_CODE;
    end else begin
      mode_reg <= next_mode;
      ctrl_reg <= next_ctrl;
      if (wr_tim) timers_reg <= wbyte;
      if (wr_fade) fades_reg <= wbyte;
      if (wr_full) full_code <= wbyte[6:0];
      if (wr_dim) dim_code <= wbyte[6:0];
    end
  end

  // target current
  wire logic ovp_ramp = ovp_seen && overvoltage_rampdown_enable;
  wire logic [6:0] lvl_full = brightness_level_select == LVL_DAY ? full_code : OTHER_FULL_CODE;
  wire logic [6:0] lvl_dim  = brightness_level_select == LVL_DAY ? dim_code : OTHER_DIM_CODE;
  wire logic [6:0] lit_code = dim_enable ? lvl_dim : lvl_full;
  wire logic [6:0] target   = (!active || ovp_ramp) ? 7'h00 : lit_code;

  blfc_fade_if fade_bus ();
  wire logic rising = target > fade_bus.code;
  wire logic [5:0] dur_sel = rising ? blfc_fade_ticks(fade_in_time_code) : blfc_fade_ticks(fade_out_time_code);
  assign fade_bus.target = target;
  assign fade_bus.dur    = dur_sel;
  assign fade_bus.curve  = fade_curve_select;
  assign fade_bus.jump   = fade_bypass || dur_sel == 6'h00;
  assign fade_bus.step   = step;

  blfc_fader u_fader (
    .clk  (clk),
    .nrst (nrst),
    .fi   (fade_bus)
  );

  // read mux; unmapped indices read zero
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      IDX_MODE:   rd_byte = mode_reg;
      IDX_CTRL:   rd_byte = ctrl_reg;
      IDX_TIMERS: rd_byte = timers_reg;
      IDX_FADES:  rd_byte = fades_reg;
      IDX_FULL:   rd_byte = {1'b0, full_code};
      IDX_DIM:    rd_byte = {1'b0, dim_code};
      IDX_VALUE:  rd_byte = {1'b0, fade_bus.code};
      default:    rd_byte = 8'h00;
    endcase
  end

  // one wait cycle per access: read data is captured while waitrequest is high, write data once it is low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      waitrequest   <= 1'b1;
      readdata      <= 32'h0000_0000;
      sink_code     <= RST_CODE;
      driver_enable <= 1'b0;
    end else begin
      waitrequest   <= !req;
      if (req && read) readdata <= {24'h00_0000, rd_byte};
      sink_code     <= fade_bus.code;
      driver_enable <= active;
    end
  end

  chk_bus_wait: assert property (@(posedge clk) disable iff (!nrst)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest) else $error("bus answer not one cycle");
  chk_level_manual: assert property (@(posedge clk) disable iff (!nrst)
    !auto_level_adjust && !wr_ctrl |=> $stable(brightness_level_select)) else $error("level moved without write");
  chk_level_auto: assert property (@(posedge clk) disable iff (!nrst)
    auto_level_adjust |=> brightness_level_select == $past(auto_level)) else $error("level not taken from comparators");
  chk_key_wake: assert property (@(posedge clk) disable iff (!nrst)
    key_wake |=> light_driver_on ##1 driver_enable) else $error("key press did not wake driver");
  chk_key_ignored: assert property (@(posedge clk) disable iff (!nrst)
    !light_driver_on && !keypress_wake_light && !wr_mode |=> !light_driver_on) else $error("driver woke without cause");
  chk_driver_off: assert property (@(posedge clk) disable iff (!nrst)
    !light_driver_on |=> !driver_enable) else $error("driver enabled while bit clear");
  chk_dim_expire: assert property (@(posedge clk) disable iff (!nrst)
    dim_expire && !key_wake |=> dim_enable) else $error("dim delay did not set dim");
  chk_dim_manual: assert property (@(posedge clk) disable iff (!nrst)
    dim_enable && !wr_mode && !(key_wake && dim_auto) |=> dim_enable) else $error("dim cleared by itself");
  chk_off_expire: assert property (@(posedge clk) disable iff (!nrst)
    off_expire && !key_wake |=> !light_driver_on ##1 !driver_enable) else $error("off delay did not clear driver");
  // the applied code may only fall while an enabled overvoltage lasts
  chk_ovp_ramp: assert property (@(posedge clk) disable iff (!nrst)
    ovp_ramp |=> fade_bus.code <= $past(fade_bus.code)) else $error("current rose during overvoltage");
  chk_code_msb: assert property (@(posedge clk) disable iff (!nrst)
    req && read && (idx == IDX_FULL || idx == IDX_DIM) |=> readdata[7] == 1'b0) else $error("unused bit read one");
  chk_day_full: assert property (@(posedge clk) disable iff (!nrst)
    active && !ovp_ramp && !dim_enable && brightness_level_select == LVL_DAY && fade_bus.jump && !fade_bus.busy
    |=> ##1 sink_code == $past(full_code, 2)) else $error("daylight full code not applied");

  cov_key_wake: cover property (@(posedge clk) disable iff (!nrst) key_wake ##1 light_driver_on);
  cov_dim_expire: cover property (@(posedge clk) disable iff (!nrst) dim_expire);
  cov_off_expire: cover property (@(posedge clk) disable iff (!nrst) off_expire);
  cov_auto_dark: cover property (@(posedge clk) disable iff (!nrst)
    auto_level_adjust && brightness_level_select == LVL_DARK);
  cov_fade_done: cover property (@(posedge clk) disable iff (!nrst) $fell(fade_bus.busy) && sink_code != 7'h00);
endmodule : blfc_top
`default_nettype wire

// *** hw/blfc_dummy_never.sv ***
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** testbench/blfc_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module blfc_top_tb
  import blfc_pkg::*;
;
  // short step keeps the 0.1 s tick at 256 cycles
  localparam int         STEP     = 2;
  localparam int         TICK     = 128 * STEP;
  localparam int         DIM_T    = 100 * TICK;
  localparam int         OFF_T    = 150 * TICK;
  localparam int         FADE_T   = 3 * TICK + 100;
  localparam logic [6:0] OFC_FULL = 7'h11;
  localparam logic [6:0] OFC_DIM  = 7'h22;

  logic        clk         = 1'b0;
  logic        nrst        = 1'b0;
  logic [5:0]  address     = 6'h00;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h00000000;
  logic [3:0]  byteenable  = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        key_press   = 1'b0;
  logic        overvoltage = 1'b0;
  logic        ambient_l2  = 1'b0;
  logic        ambient_l3  = 1'b0;
  logic [6:0]  sink_code;
  logic        driver_enable;
  logic [7:0]  rdv;
  int          failures    = 0;
  int          checks      = 0;

  always #2.5 clk = ~clk;

  blfc_top #(.STEP_CYCLES(STEP), .OTHER_FULL_CODE(OFC_FULL), .OTHER_DIM_CODE(OFC_DIM)) blfc_top_inst (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .key_press(key_press), .overvoltage(overvoltage),
    .ambient_l2(ambient_l2), .ambient_l3(ambient_l3), .sink_code(sink_code),
    .driver_enable(driver_enable)
  );

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic is_wr, input logic [3:0] idx, input logic [7:0] wd, input logic [3:0] be);
    address    <= {idx, 2'h0};
    writedata  <= {24'h000000, wd};
    byteenable <= be;
    write      <= is_wr;
    read       <= ~is_wr;
    @(posedge clk);
    // only the watchdog ends a wait that never gets an answer
    while (waitrequest !== 1'b0) @(posedge clk);
    rdv = readdata[7:0];
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input string what);
    bus(1'b0, idx, 8'h00, 4'hF);
    chk_val(what, exp, rdv);
  endtask : rd

  task automatic wait_sink(input logic [6:0] exp, input int lim, input string what);
    int n;
    n = 0;
    while (sink_code !== exp && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk_val(what, {1'b0, exp}, {1'b0, sink_code});
  endtask : wait_sink

  task automatic key_pulse;
    key_press <= 1'b1;
    repeat (6) @(posedge clk);
    key_press <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : key_pulse

  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  logic [3:0] all_idx [9] = '{IDX_MODE, 4'h1, IDX_CTRL, IDX_TIMERS, IDX_FADES, IDX_FULL, IDX_DIM, IDX_VALUE, 4'hF};
  logic [1:0] lvl;
  // code expected half way through a fade-in per curve, with a margin for the step phase
  logic [6:0] mid_lo [4] = '{7'h37, 7'h17, 7'h07, 7'h67};
  logic [6:0] mid_hi [4] = '{7'h47, 7'h27, 7'h17, 7'h77};

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd(all_idx[i], 8'h00, "reset_value");
    wr(IDX_TIMERS, 8'hA5);
    rd(IDX_TIMERS, 8'hA5, "timers");
    wr(IDX_FADES, 8'h5A);
    rd(IDX_FADES, 8'h5A, "fades");
    wr(IDX_FULL, 8'hFF);
    rd(IDX_FULL, 8'h7F, "full_code");
    wr(IDX_DIM, 8'hD5);
    rd(IDX_DIM, 8'h55, "dim_code");
    bus(1'b1, IDX_DIM, 8'h11, 4'hE);
    rd(IDX_DIM, 8'h55, "dim_no_lane");
    wr(IDX_VALUE, 8'h33);
    rd(IDX_VALUE, 8'h00, "value_ro");
    wr(IDX_MODE, 8'h1F);
    rd(IDX_MODE, 8'h00, "mode_low");
    // level code 11 is refused, so the field keeps dark
    for (int i = 0; i < 4; i++) begin
      lvl = (i == 3) ? 2'h2 : 2'(i);
      wr(IDX_CTRL, {2'(i), 2'(i), 4'h2});
      rd(IDX_CTRL, {lvl, 2'(i), 4'h2}, "level_curve");
    end
    wr(IDX_CTRL, 8'h02);
    wr(IDX_TIMERS, 8'h00);
    wr(IDX_MODE, 8'h40);
    repeat (4) @(posedge clk);
    chk_val("drv_standby", 8'h00, {7'h00, driver_enable});
    wr(IDX_MODE, 8'hC0);
    repeat (4) @(posedge clk);
    chk_val("drv_on", 8'h01, {7'h00, driver_enable});
    wait_sink(7'h7F, 20, "full_bypass");
    wr(IDX_MODE, 8'hE0);
    wait_sink(7'h55, 20, "dim_manual");
    wr(IDX_CTRL, 8'h42);
    wait_sink(OFC_DIM, 20, "office_dim");
    wr(IDX_MODE, 8'hC0);
    wait_sink(OFC_FULL, 20, "office_full");
    ambient_l3 <= 1'b1;
    repeat (10) @(posedge clk);
    rd(IDX_CTRL, 8'h42, "manual_level");
    wr(IDX_CTRL, 8'h0A);
    repeat (10) @(posedge clk);
    rd(IDX_CTRL, 8'h8A, "auto_dark");
    ambient_l3 <= 1'b0;
    ambient_l2 <= 1'b1;
    repeat (10) @(posedge clk);
    rd(IDX_CTRL, 8'h4A, "auto_office");
    ambient_l2 <= 1'b0;
    repeat (10) @(posedge clk);
    rd(IDX_CTRL, 8'h0A, "auto_day");
    wr(IDX_CTRL, 8'h02);
    wait_sink(7'h7F, 20, "day_full");
    overvoltage <= 1'b1;
    repeat (10) @(posedge clk);
    chk_val("ovp_off", 8'h7F, {1'b0, sink_code});
    wr(IDX_CTRL, 8'h06);
    wait_sink(7'h00, 20, "ovp_ramp");
    overvoltage <= 1'b0;
    wait_sink(7'h7F, 20, "ovp_gone");
    // fade-out code 0 lets each pass restart from zero at once
    wr(IDX_FADES, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CTRL, 8'h02);
      wr(IDX_MODE, 8'h80);
      wait_sink(7'h00, 20, "fade_restart");
      wr(IDX_CTRL, {2'h0, 2'(c), 4'h0});
      wr(IDX_MODE, 8'hC0);
      repeat (40) @(posedge clk);
      chk_val("fade_in_mid", 8'h01, {7'h00, sink_code < 7'h7F});
      repeat (344) @(posedge clk);
      chk_val("fade_in_curve", 8'h01, {7'h00, sink_code >= mid_lo[c] && sink_code <= mid_hi[c]});
      wait_sink(7'h7F, FADE_T, "fade_in_end");
    end
    wr(IDX_FADES, 8'h10);
    wr(IDX_MODE, 8'h80);
    repeat (40) @(posedge clk);
    chk_val("fade_out_mid", 8'h01, {7'h00, sink_code > 7'h00});
    wait_sink(7'h00, FADE_T, "fade_out_end");
    wr(IDX_CTRL, 8'h02);
    wr(IDX_TIMERS, 8'h21);
    wr(IDX_MODE, 8'hC0);
    repeat (DIM_T - 600) @(posedge clk);
    rd(IDX_MODE, 8'hC0, "before_dim");
    repeat (1200) @(posedge clk);
    rd(IDX_MODE, 8'hE0, "dim_expired");
    wait_sink(7'h55, 20, "dim_level");
    repeat (OFF_T - DIM_T - 1300) @(posedge clk);
    chk_val("before_off", 8'h01, {7'h00, driver_enable});
    repeat (1200) @(posedge clk);
    chk_val("off_expired", 8'h00, {7'h00, driver_enable});
    wait_sink(7'h00, 20, "off_level");
    wr(IDX_TIMERS, 8'h00);
    wr(IDX_MODE, 8'h80);
    key_pulse();
    rd(IDX_MODE, 8'h80, "key_ignored");
    // key wake is armed while in standby, before operating mode
    wr(IDX_MODE, 8'h00);
    wr(IDX_CTRL, 8'h03);
    wr(IDX_MODE, 8'h80);
    key_pulse();
    rd(IDX_MODE, 8'hC0, "key_wake");
    chk_val("key_drv", 8'h01, {7'h00, driver_enable});
    wait_sink(7'h7F, 20, "key_level");
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : blfc_top_tb
`default_nettype wire
